// >>> skip_call_pkg.sv
// constants for the skip/call/clear/complement decode and execute block
// assumes one core clock; fetch supplies one 14-bit word per issue
package skip_call_pkg;
  localparam int          INSN_W        = 14;
  localparam int          PC_W          = 12;
  localparam int          DATA_W        = 8;
  localparam int          FADDR_W       = 7;
  localparam logic [13:0] CLEAR_ACCUMULATOR_WORD     = 14'h0140;
  localparam logic [13:0] KICK_WORD     = 14'h0004;
  localparam logic [6:0]  CLEAR_FILE_REG_TOP      = 7'h03;
  localparam logic [5:0]  INVERT_FILE_REG_TOP      = 6'h09;
  localparam logic [4:0]  BTSS_TOP      = 5'h0B;
  localparam logic [1:0]  CALL_TOP      = 2'h2;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam logic [7:0]  WDOG_RESET    = 8'h00;
  localparam logic [11:0] PC_RESET      = 12'h000;
  localparam logic        TIMEOUT_RESET = 1'b1;
  localparam logic        SLEEP_RESET   = 1'b1;
  typedef enum logic [2:0] {
    OP_NONE, OP_BTSS, OP_CALL, OP_CLEAR_FILE_REG, OP_CLEAR_ACCUMULATOR, OP_KICK, OP_INVERT_FILE_REG
  } op_e;
endpackage : skip_call_pkg

// >>> skip_call_decode.sv
// pure decoder of one instruction word into an operation class
// assumes the word is stable while valid
`timescale 1ns/100ps
module skip_call_decode
  import skip_call_pkg::*;
(
  input  wire logic [skip_call_pkg::INSN_W-1:0] insn_i,
  output skip_call_pkg::op_e                    op_o
);
  always_comb begin
    op_o = OP_NONE;
    if (insn_i == CLEAR_ACCUMULATOR_WORD) begin
      op_o = OP_CLEAR_ACCUMULATOR;
    end else if (insn_i == KICK_WORD) begin
      op_o = OP_KICK;
    end else if (insn_i[13:7] == CLEAR_FILE_REG_TOP) begin
      op_o = OP_CLEAR_FILE_REG;
    end else if (insn_i[13:8] == INVERT_FILE_REG_TOP) begin
      op_o = OP_INVERT_FILE_REG;
    end else if (insn_i[13:9] == BTSS_TOP) begin
      op_o = OP_BTSS;
    end else if (insn_i[13:12] == CALL_TOP) begin
      op_o = OP_CALL;
    end
  end
endmodule : skip_call_decode

// >>> bit_skip_call_clear_ops.sv
// execute stage for skip, call, clear and complement operations
// assumes register file read is combinational via rd_addr_o/rd_data_i
`timescale 1ns/100ps
module bit_skip_call_clear_ops
  import skip_call_pkg::*;
#(
  parameter int DATA_WIDTH = 8
) (
  input  wire logic                          ref_clk_i,
  input  wire logic                          reset_n_i,
  input  wire logic                          insn_valid_i,
  input  wire logic [skip_call_pkg::INSN_W-1:0] insn_i,
  input  wire logic [skip_call_pkg::PC_W-1:0]   insn_pc_i,
  output logic [skip_call_pkg::FADDR_W-1:0]  rd_addr_o,
  input  wire logic [DATA_WIDTH-1:0]         rd_data_i,
  input  wire logic                          watchdog_timeout_i,
  output logic                               busy_o,
  output logic                               squash_o,
  output logic                               pc_load_o,
  output logic [skip_call_pkg::PC_W-1:0]     program_counter_o,
  output logic                               push_o,
  output logic [skip_call_pkg::PC_W-1:0]     stack_head_o,
  output logic                               reg_we_o,
  output logic [skip_call_pkg::FADDR_W-1:0]  reg_waddr_o,
  output logic [DATA_WIDTH-1:0]              reg_wdata_o,
  output logic [DATA_WIDTH-1:0]              accumulator_o,
  output logic                               zero_flag_o,
  output logic [DATA_WIDTH-1:0]              watchdog_counter_o,
  output logic                               timeout_flag_o,
  output logic                               sleep_entered_flag_o
);
  import skip_call_pkg::*;

  // the byte-wide datapath cannot serve any other width
  if (DATA_WIDTH != DATA_W) begin : g_bad_width
    $error("DATA_WIDTH must equal 8");
  end

  // ********************************************
  // decode
  // ********************************************
  op_e                  op;
  logic                 second_cycle;
  logic                 issue;
  logic [DATA_WIDTH-1:0] inverted;

  skip_call_decode u_decode (
    .insn_i (insn_i),
    .op_o   (op)
  );

  // the second cycle of a two-cycle op takes no new word
  assign issue    = insn_valid_i && !second_cycle;
  assign inverted = ~rd_data_i;

  always_comb begin
    rd_addr_o = insn_i[FADDR_W-1:0];
    if (op == OP_BTSS) begin
      rd_addr_o = {1'b0, insn_i[5:0]};
    end
  end

  // ********************************************
  // cycle control
  // ********************************************
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      second_cycle <= 1'b0;
      squash_o     <= 1'b0;
      busy_o       <= 1'b0;
    end else begin
      second_cycle <= 1'b0;
      squash_o     <= 1'b0;
      busy_o       <= 1'b0;
      if (issue && op == OP_BTSS && rd_data_i[insn_i[8:6]]) begin
        second_cycle <= 1'b1;
        squash_o     <= 1'b1;
        busy_o       <= 1'b1;
      end else if (issue && op == OP_CALL) begin
        second_cycle <= 1'b1;
        squash_o     <= 1'b1;
        busy_o       <= 1'b1;
      end
    end
  end

  // ********************************************
  // program counter and return stack
  // ********************************************
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pc_load_o         <= 1'b0;
      program_counter_o <= PC_RESET;
      push_o            <= 1'b0;
      stack_head_o      <= PC_RESET;
    end else begin
      pc_load_o <= 1'b0;
      push_o    <= 1'b0;
      if (issue && op == OP_CALL) begin
        pc_load_o         <= 1'b1;
        program_counter_o <= insn_i[PC_W-1:0];
        push_o            <= 1'b1;
        stack_head_o      <= insn_pc_i + 12'h001;
      end
    end
  end

  // ********************************************
  // register file write and accumulator
  // ********************************************
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_we_o    <= 1'b0;
      reg_waddr_o <= '0;
      reg_wdata_o <= ZERO_BYTE;
    end else begin
      reg_we_o <= 1'b0;
      if (issue && op == OP_CLEAR_FILE_REG) begin
        reg_we_o    <= 1'b1;
        reg_waddr_o <= insn_i[FADDR_W-1:0];
        reg_wdata_o <= ZERO_BYTE;
      end else if (issue && op == OP_INVERT_FILE_REG && insn_i[7]) begin
        reg_we_o    <= 1'b1;
        reg_waddr_o <= insn_i[FADDR_W-1:0];
        reg_wdata_o <= inverted;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      accumulator_o <= ZERO_BYTE;
    end else if (issue && op == OP_CLEAR_ACCUMULATOR) begin
      accumulator_o <= ZERO_BYTE;
    end else if (issue && op == OP_INVERT_FILE_REG && !insn_i[7]) begin
      accumulator_o <= inverted;
    end
  end

  // skip and call leave all flags alone
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      zero_flag_o <= 1'b0;
    end else if (issue && (op == OP_CLEAR_FILE_REG || op == OP_CLEAR_ACCUMULATOR)) begin
      zero_flag_o <= 1'b1;
    end else if (issue && op == OP_INVERT_FILE_REG) begin
      zero_flag_o <= (inverted == ZERO_BYTE);
    end
  end

  // ********************************************
  // watchdog counter and power flags
  // ********************************************
  // counter here advances on every clock that is not a kick; the kick clears it
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      watchdog_counter_o   <= WDOG_RESET;
      timeout_flag_o       <= TIMEOUT_RESET;
      sleep_entered_flag_o <= SLEEP_RESET;
    end else if (issue && op == OP_KICK) begin
      watchdog_counter_o   <= WDOG_RESET;
      timeout_flag_o       <= 1'b1;
      sleep_entered_flag_o <= 1'b1;
    end else begin
      watchdog_counter_o <= watchdog_counter_o + 8'h01;
      if (watchdog_timeout_i) begin
        timeout_flag_o <= 1'b0;
      end
    end
  end
endmodule : bit_skip_call_clear_ops

// >>> bit_skip_call_clear_ops_asserts.sv
// checker for the skip/call/clear/complement execute block
// assumes it is bound to every instance of that block
`timescale 1ns/100ps
module skip_call_asserts
  import skip_call_pkg::*;
#(
  parameter int DATA_WIDTH = 8
) (
  input wire logic                  ref_clk_i,
  input wire logic                  reset_n_i,
  input wire logic                  insn_valid_i,
  input wire logic [13:0]           insn_i,
  input wire logic [11:0]           insn_pc_i,
  input wire logic [6:0]            rd_addr_o,
  input wire logic [DATA_WIDTH-1:0] rd_data_i,
  input wire logic                  watchdog_timeout_i,
  input wire logic                  busy_o,
  input wire logic                  squash_o,
  input wire logic                  pc_load_o,
  input wire logic [11:0]           program_counter_o,
  input wire logic                  push_o,
  input wire logic [11:0]           stack_head_o,
  input wire logic                  reg_we_o,
  input wire logic [6:0]            reg_waddr_o,
  input wire logic [DATA_WIDTH-1:0] reg_wdata_o,
  input wire logic [DATA_WIDTH-1:0] accumulator_o,
  input wire logic                  zero_flag_o,
  input wire logic [DATA_WIDTH-1:0] watchdog_counter_o,
  input wire logic                  timeout_flag_o,
  input wire logic                  sleep_entered_flag_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // a word offered in the second cycle is not taken
  wire tk = insn_valid_i && !busy_o;
  wire bt = tk && insn_i[13:9] == 5'h0B;
  wire cf = tk && insn_i[13:8] == 6'h09;
  wire [7:0] inv = ~rd_data_i;
  AST_CALL: assert property (tk && insn_i[13:12] == 2'h2 |=>
    pc_load_o && push_o && busy_o && stack_head_o == $past(insn_pc_i) + 12'h001
    && program_counter_o == $past(insn_i[11:0])) else $error("call wrong");
  AST_SKIP: assert property (bt && rd_data_i[insn_i[8:6]] |=>
    squash_o && busy_o ##1 !busy_o) else $error("skip wrong");
  AST_NOSKIP: assert property (bt && !rd_data_i[insn_i[8:6]] |=>
    !busy_o && !squash_o && $stable(zero_flag_o)) else $error("no skip wrong");
  AST_BTADDR: assert property (bt |-> rd_addr_o == {1'b0, insn_i[5:0]})
    else $error("bit test address wrong");
  AST_CLEAR_FILE_REG: assert property (tk && insn_i[13:7] == 7'h03 |=>
    reg_we_o && reg_wdata_o == 8'h00 && zero_flag_o
    && reg_waddr_o == $past(insn_i[6:0])) else $error("clear reg wrong");
  AST_CLEAR_ACCUMULATOR: assert property (tk && insn_i == 14'h0140 |=>
    accumulator_o == 8'h00 && zero_flag_o && !reg_we_o) else $error("clr acc");
  AST_KICK: assert property (tk && insn_i == 14'h0004 && !watchdog_timeout_i
    |=> watchdog_counter_o == 8'h00 && timeout_flag_o && sleep_entered_flag_o)
    else $error("kick wrong");
  AST_INVERT_FILE_REG_ACC: assert property (cf && !insn_i[7] |=>
    accumulator_o == $past(inv) && !reg_we_o
    && zero_flag_o == (accumulator_o == 8'h00)) else $error("inv acc wrong");
  AST_INVERT_FILE_REG_REG: assert property (cf && insn_i[7] |=>
    reg_we_o && reg_wdata_o == $past(inv) && reg_waddr_o == $past(insn_i[6:0])
    && $stable(accumulator_o)) else $error("inv reg wrong");
  cover property (tk && insn_i[13:12] == 2'h2);
  cover property (squash_o);
  cover property (reg_we_o);
endmodule : skip_call_asserts
bind bit_skip_call_clear_ops skip_call_asserts #(.DATA_WIDTH(DATA_WIDTH))
  skip_call_asserts_inst (.ref_clk_i, .reset_n_i, .insn_valid_i, .insn_i,
  .insn_pc_i, .rd_addr_o, .rd_data_i, .watchdog_timeout_i, .busy_o, .squash_o,
  .pc_load_o, .program_counter_o, .push_o, .stack_head_o, .reg_we_o,
  .reg_waddr_o, .reg_wdata_o, .accumulator_o, .zero_flag_o,
  .watchdog_counter_o, .timeout_flag_o, .sleep_entered_flag_o);

// >>> bit_skip_call_clear_ops_tb.sv
// self-checking bench for the skip/call/clear/complement execute block
// assumes the package, design and checker are compiled before it
`timescale 1ns/100ps
module bit_skip_call_clear_ops_tb;
  import skip_call_pkg::*;
  logic ref_clk_i, reset_n_i, insn_valid_i, watchdog_timeout_i;
  logic [13:0] insn_i, w;
  logic [11:0] head_exp;
  logic [11:0] insn_pc_i, program_counter_o, stack_head_o;
  logic [6:0] rd_addr_o, reg_waddr_o;
  logic [7:0] rd_data_i, reg_wdata_o, accumulator_o, watchdog_counter_o;
  logic busy_o, squash_o, pc_load_o, push_o, reg_we_o, zero_flag_o;
  logic timeout_flag_o, sleep_entered_flag_o;
  int miscompares = 0, cmp_count = 0, cycles = 0;
  bit_skip_call_clear_ops bit_skip_call_clear_ops_inst (.ref_clk_i,
    .reset_n_i, .insn_valid_i, .insn_i, .insn_pc_i, .rd_addr_o, .rd_data_i,
    .watchdog_timeout_i, .busy_o, .squash_o, .pc_load_o, .program_counter_o,
    .push_o, .stack_head_o, .reg_we_o, .reg_waddr_o, .reg_wdata_o,
    .accumulator_o, .zero_flag_o, .watchdog_counter_o, .timeout_flag_o,
    .sleep_entered_flag_o);
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // the run takes about 36 cycles; the guard ends it at 2000
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      give_verdict();
    end
  end
  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // offers a word for one edge; the pc is derived so calls test wrap
  task op(input logic [13:0] wd, input logic [7:0] d);
    insn_valid_i <= 1'b1;
    insn_i <= wd;
    insn_pc_i <= ~wd[11:0];
    rd_data_i <= d;
    @(posedge ref_clk_i);
    insn_valid_i <= 1'b0;
    #1;
  endtask : op
  initial begin
    reset_n_i = 1'b0;
    insn_valid_i = 1'b0;
    watchdog_timeout_i = 1'b0;
    insn_i = 14'h0000;
    insn_pc_i = 12'h000;
    rd_data_i = 8'h00;
    repeat (2) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    #1;
    chk("reset", {timeout_flag_o, sleep_entered_flag_o, busy_o}, 3'b110);
    for (int k = 0; k < 2; k++) begin
      w = k ? 14'h2ABC : 14'h2000;
      head_exp = ~w[11:0] + 12'h001;
      op(w, 8'h00);
      chk("target", program_counter_o, w[11:0]);
      chk("head", stack_head_o, head_exp);
      chk("two cyc", {busy_o, squash_o, pc_load_o, push_o}, 4'hF);
      op(14'h01C5, 8'h00);
      chk("refused", reg_we_o, 1'b0);
    end
    op(14'h01C5, 8'h77);
    chk("clr reg", {reg_we_o, reg_waddr_o, reg_wdata_o}, 16'hC500);
    chk("clr z", zero_flag_o, 1'b1);
    op(14'h0912, 8'h13);
    chk("inv acc", {reg_we_o, zero_flag_o, accumulator_o}, 10'h0EC);
    op(14'h0992, 8'h5A);
    chk("inv reg", {reg_we_o, reg_waddr_o, reg_wdata_o}, 16'h92A5);
    chk("acc kept", accumulator_o, 8'hEC);
    op(14'h0140, 8'h5A);
    chk("clr acc", {reg_we_o, zero_flag_o, accumulator_o}, 10'h100);
    for (int b = 0; b < 8; b++) begin
      w = {5'h0B, b[2:0], 6'h2A};
      op(w, ~(8'h01 << b));
      chk("no skip", {busy_o, squash_o, zero_flag_o}, 3'b001);
      op(w, 8'h01 << b);
      chk("skip", {busy_o, squash_o, zero_flag_o}, 3'b111);
      @(posedge ref_clk_i);
      #1;
    end
    watchdog_timeout_i <= 1'b1;
    @(posedge ref_clk_i);
    watchdog_timeout_i <= 1'b0;
    #1;
    chk("timeout", timeout_flag_o, 1'b0);
    op(14'h0004, 8'h00);
    chk("kick", {watchdog_counter_o, timeout_flag_o, sleep_entered_flag_o},
        10'h003);
    give_verdict();
  end
endmodule : bit_skip_call_clear_ops_tb
